// ==== hv_flags_pkg.sv ====
// Constants for the high-side fault and state flag registers
// Summary of operation
// - Both status registers read-only, flags active high
// - Clear command or pin zeroes clearable flags
// - Power-on and command reset fully reset flags
// - Persisting fault sets its flag again immediately
// - Supply overvoltage bits 7,6 latch, force protected-off
// - Three-phase-short state held on those faults
// - Desaturation bit 5 latches, forces protected-off
// - Shunt overcurrent bit 4 latches, forces protected-off
// - Bit 0 busy when other bits invalid
// - Busy re-evaluated per read, never latches
// - State bit 7 tracks protected-off state
// - Reset-seen bit 6 latches, forces protected-off
// - Thermal warning bit 4 follows comparator only
// - Config pending set by reset/begin, cleared by end
// - Power-on during config reads zero after end
// - Config mismatch bit 2 latches, forces protected-off
// - Fault register read-only, flags active high
package hv_flags_pkg;
   localparam int FLAG_W = 8;
   // Fault register bit positions
   localparam int F_OVH = 7;
   localparam int F_OVL = 6;
   localparam int F_COLLECTOR_MONITOR_PIN = 5;
   localparam int F_SHUNT = 4;
   localparam int F_UVH = 3;
   localparam int F_UVL = 2;
   localparam int F_TSD = 1;
   localparam int F_BUSY = 0;
   // State register bit positions
   localparam int S_PROT = 7;
   localparam int S_RST = 6;
   localparam int S_TWN = 4;
   localparam int S_CFG = 3;
   localparam int S_MIS = 2;
   localparam int S_LINK = 1;
   localparam int S_BUSY = 0;
   // Register selector for a read
   localparam logic SEL_FAULT = 1'h0;
   localparam logic SEL_STATE = 1'h1;
   // Values after reset; busy bit reads zero when settled
   localparam logic [7:0] FAULT_RST = 8'h00;
   localparam logic [7:0] STATE_RST = 8'hC8;
   localparam logic [7:0] LATCH_CLR_MASK = 8'h00;
   // Operating states of the high side
   typedef enum logic [2:0] {
      ST_RUN = 3'h1,
      ST_PROT = 3'h2,
      ST_SHORT = 3'h4
   } hv_state_t;
endpackage

// ==== flag_cell.sv ====
// One status flag cell: latched or transparent, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module flag_cell
   import hv_flags_pkg::*;
(
   input wire logic core_clk, // Clock
   input wire logic rst_n, // Synchronised reset, low active
   input wire logic rst_val, // Value loaded by a clear event; reset loads zero
   input wire logic cond, // Fault condition present
   input wire logic latch_en, // High: flag latches
   input wire logic clr, // Clear event
   output logic flag_r // Flag
);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_r <= 1'h0;
      end else if (cond) begin
         flag_r <= 1'h1;
      end else if (clr) begin
         // Power-on always zero; a clear loads the owner's cleared value
         flag_r <= rst_val;
      end else if (!latch_en) begin
         flag_r <= 1'h0;
      end
   end
endmodule
`default_nettype wire

// ==== hv_side_fault_status_flags.sv ====
// High-side fault and state flag register bank
`timescale 1ns/1ps
`default_nettype none
module hv_side_fault_status_flags
   import hv_flags_pkg::*;
(
   input wire logic core_clk, // 10 MHz clock
   input wire logic resetn, // High-side power-on reset, low active
   input wire logic positive_gate_supply_ov, // Overvoltage comparator
   input wire logic negative_gate_supply_ov, // Overvoltage comparator
   input wire logic collector_monitor_pin, // Desaturation comparator
   input wire logic shunt_trip, // Shunt threshold comparator
   input wire logic positive_gate_supply_uv, // Below off threshold
   input wire logic negative_gate_supply_uv, // Undervoltage comparator
   input wire logic thermal_shutdown_cmp, // Shutdown comparator with hysteresis
   input wire logic thermal_warning_cmp, // Warning comparator with hysteresis
   input wire logic config_mismatch, // Mismatch seen in config registers
   input wire logic link_timeout, // Watchdog window expired
   input wire logic fallback_short_pin, // High: fallback is short state
   input wire logic undervoltage_latch_option, // Latch undervoltage flags
   input wire logic flag_clear_command, // Clear pulse from command
   input wire logic shutdown_pin_clear, // Clear pulse from shutdown pin
   input wire logic command_reset, // Soft reset pulse
   input wire logic config_begin_command, // Begin pulse
   input wire logic config_end_command, // End pulse
   input wire logic config_mode, // Configuration mode active
   input wire logic data_settling, // Flag sources not yet stable
   input wire logic exit_protected, // Request to leave protected state
   input wire logic rd_strobe, // Read pulse
   input wire logic rd_sel, // 0 fault register, 1 state register
   output logic [7:0] rd_data_r, // Read data, held until next read
   output logic protected_off_state_r, // In protected-off state
   output logic three_phase_short_state_r // In three-phase-short state
);
   // =====================================================
   // Reset synchroniser
   logic rst_s1_r, rst_n_r;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_r <= 1'h0;
         rst_n_r <= 1'h0;
      end else begin
         rst_s1_r <= 1'h1;
         rst_n_r <= rst_s1_r;
      end
   end

   // =====================================================
   // Clear and reset events
   logic clr, srst, por_in_cfg_r, first_r;
   assign clr = flag_clear_command | shutdown_pin_clear;
   assign srst = command_reset;

   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         first_r <= 1'h1;
      end else begin
         first_r <= 1'h0;
      end
   end

   // =====================================================
   // Fault flags, all active high and read-only
   logic [7:1] fault_r;
   logic [7:1] fault_cond, fault_lat;
   assign fault_cond = {positive_gate_supply_ov, negative_gate_supply_ov,
      collector_monitor_pin, shunt_trip, positive_gate_supply_uv,
      negative_gate_supply_uv, thermal_shutdown_cmp};
   // Bits 7..4 latch; undervoltage latches on option; shutdown follows
   assign fault_lat = {4'hF, undervoltage_latch_option, undervoltage_latch_option, 1'h0};

   // Soft reset clears fault flags exactly as a clear event does
   for (genvar i = 1; i < FLAG_W; i++) begin : g_fault
      flag_cell flag_cell_i (
         .core_clk(core_clk), // Clock
         .rst_n(rst_n_r), // Synchronised reset
         .rst_val(FAULT_RST[i]), // Value after clear
         .cond(fault_cond[i]),
         .latch_en(fault_lat[i]), // Latch or follow
         .clr(clr | srst),
         .flag_r(fault_r[i]) // Flag
      );
   end

   // =====================================================
   // State flags
   logic reset_seen_r, mismatch_r, link_r, cfg_pending_r;
   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         reset_seen_r <= STATE_RST[S_RST];
      end else if (srst) begin
         reset_seen_r <= 1'h1;
      end else if (clr) begin
         reset_seen_r <= 1'h0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mismatch_r <= 1'h0;
      end else if (config_mismatch) begin
         mismatch_r <= 1'h1;
      end else if (clr || srst) begin
         mismatch_r <= 1'h0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         link_r <= 1'h0;
      end else if (link_timeout) begin
         link_r <= 1'h1;
      end else if (clr || srst) begin
         link_r <= 1'h0;
      end
   end

   // Config pending ignores clear events
   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         cfg_pending_r <= STATE_RST[S_CFG];
         por_in_cfg_r <= 1'h0;
      end else begin
         if (first_r && config_mode) begin
            por_in_cfg_r <= 1'h1;
         end else if (config_end_command) begin
            por_in_cfg_r <= 1'h0;
         end
         if (srst || config_begin_command) begin
            cfg_pending_r <= 1'h1;
         end else if (config_end_command && (config_mode || por_in_cfg_r)) begin
            cfg_pending_r <= 1'h0;
         end
      end
   end

   // =====================================================
   // Operating state
   hv_state_t st_r;
   logic force_prot, force_short;
   // Reset-seen also forces protected-off until cleared
   assign force_prot = fault_r[F_OVH] | fault_r[F_OVL] | fault_r[F_COLLECTOR_MONITOR_PIN] |
      fault_r[F_SHUNT] | fault_r[F_UVH] | fault_r[F_UVL] | fault_r[F_TSD] |
      reset_seen_r | mismatch_r | (link_r & !fallback_short_pin);
   assign force_short = link_r & fallback_short_pin;
   // Raw negative-supply and link faults pin the short state at once
   logic short_hold;
   assign short_hold = negative_gate_supply_ov | negative_gate_supply_uv | link_timeout;

   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         st_r <= ST_PROT;
      end else begin
         unique case (st_r)
            ST_RUN: begin
               if (force_short) begin
                  st_r <= ST_SHORT;
               end else if (force_prot) begin
                  st_r <= ST_PROT;
               end
            end
            ST_PROT: begin
               if (force_short) begin
                  st_r <= ST_SHORT;
               end else if (!force_prot && exit_protected) begin
                  st_r <= ST_RUN;
               end
            end
            ST_SHORT: begin
               // Stays put on supply or link faults; leaves only when all clear
               if (!force_short && !force_prot && !short_hold && exit_protected) begin
                  st_r <= ST_RUN;
               end
            end
            default: st_r <= ST_PROT;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         protected_off_state_r <= 1'h1;
         three_phase_short_state_r <= 1'h0;
      end else begin
         protected_off_state_r <= (st_r == ST_PROT);
         three_phase_short_state_r <= (st_r == ST_SHORT);
      end
   end

   logic [7:0] state_flags;
   assign state_flags = {st_r == ST_PROT, reset_seen_r, 1'h0,
      thermal_warning_cmp, cfg_pending_r, mismatch_r, link_r, 1'h0};

   // =====================================================
   // Read port; busy is judged per read and never held
   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rd_data_r <= 8'h00;
      end else if (rd_strobe) begin
         if (rd_sel == SEL_FAULT) begin
            rd_data_r <= {fault_r[7:1], data_settling};
         end else begin
            rd_data_r <= {state_flags[7:1], data_settling};
         end
      end
   end

   // =====================================================
   // Checks
   // Host repeats config after mismatch; nothing enforced here
   ovh_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      positive_gate_supply_ov |=> fault_r[F_OVH] ##1 (st_r != ST_RUN))
      else $error("overvoltage flag not latched");
   ovh_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      fault_r[F_OVH] && !clr && !srst |=> fault_r[F_OVH])
      else $error("overvoltage flag dropped");
   ovl_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      negative_gate_supply_ov |=> fault_r[F_OVL] ##1 (st_r != ST_RUN))
      else $error("negative overvoltage flag not latched");
   collector_monitor_pin_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      fault_r[F_COLLECTOR_MONITOR_PIN] && !clr && !srst |=> fault_r[F_COLLECTOR_MONITOR_PIN])
      else $error("desaturation flag dropped");
   collector_monitor_pin_force_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      collector_monitor_pin |=> fault_r[F_COLLECTOR_MONITOR_PIN] ##1 (st_r != ST_RUN))
      else $error("desaturation did not protect");
   shunt_set_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      shunt_trip |=> fault_r[F_SHUNT] ##1 (st_r != ST_RUN))
      else $error("shunt flag not set");
   shunt_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      fault_r[F_SHUNT] && !clr && !srst |=> fault_r[F_SHUNT])
      else $error("shunt flag dropped");
   clear_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      clr && !(|fault_cond) |=> fault_r == 7'h00)
      else $error("clear left fault flags");
   soft_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      srst && !(|fault_cond) && !config_mismatch && !link_timeout
         |=> fault_r == 7'h00 && cfg_pending_r && !mismatch_r && !link_r)
      else $error("soft reset left flags");
   uvh_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      !undervoltage_latch_option && !positive_gate_supply_uv |=> !fault_r[F_UVH])
      else $error("unlatched undervoltage held");
   uvh_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      undervoltage_latch_option && fault_r[F_UVH] && !clr && !srst |=> fault_r[F_UVH])
      else $error("latched undervoltage dropped");
   uvl_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      !undervoltage_latch_option && !negative_gate_supply_uv |=> !fault_r[F_UVL])
      else $error("unlatched negative undervoltage held");
   tsd_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      thermal_shutdown_cmp ##1 !thermal_shutdown_cmp |=> !fault_r[F_TSD])
      else $error("shutdown flag latched");
   tsd_force_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      thermal_shutdown_cmp |=> fault_r[F_TSD] ##1 (st_r != ST_RUN))
      else $error("shutdown did not protect");
   cfg_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      cfg_pending_r && clr && !config_end_command |=> cfg_pending_r)
      else $error("clear removed config pending");
   cfg_begin_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      config_begin_command || srst |=> cfg_pending_r)
      else $error("config pending not set");
   cfg_end_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      config_end_command && config_mode && !config_begin_command && !srst |=> !cfg_pending_r)
      else $error("config pending not cleared");
   short_stay_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      st_r == ST_SHORT && (negative_gate_supply_ov || negative_gate_supply_uv ||
         link_timeout) |=> st_r == ST_SHORT)
      else $error("short state left on fault");
   reset_seen_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      srst |=> reset_seen_r ##1 (st_r != ST_RUN))
      else $error("soft reset not recorded");
   reset_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      reset_seen_r && clr && !srst |=> !reset_seen_r)
      else $error("reset seen not cleared");
   prot_track_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      rd_strobe && rd_sel == SEL_STATE |=> rd_data_r[S_PROT] == protected_off_state_r)
      else $error("protected bit disagrees with state");
   twn_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      rd_strobe && rd_sel == SEL_STATE |=> rd_data_r[S_TWN] == $past(thermal_warning_cmp))
      else $error("warning bit not following");
   mismatch_set_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      config_mismatch |=> mismatch_r ##1 (st_r != ST_RUN))
      else $error("mismatch not latched");
   mismatch_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      mismatch_r && !clr && !srst |=> mismatch_r)
      else $error("mismatch flag dropped");
   link_set_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      link_timeout |=> link_r ##1 (st_r != ST_RUN))
      else $error("link timeout not latched");
   link_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      link_r && !clr && !srst |=> link_r)
      else $error("link timeout flag dropped");
   link_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      link_timeout && fallback_short_pin ##1 fallback_short_pin |=> st_r == ST_SHORT)
      else $error("fallback short not taken");
   fault_read_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      rd_strobe && rd_sel == SEL_FAULT |=> rd_data_r[7:1] == $past(fault_r))
      else $error("fault read data wrong");
   state_read_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      rd_strobe && rd_sel == SEL_STATE |=> rd_data_r[S_CFG] == $past(cfg_pending_r))
      else $error("config pending read wrong");
   busy_read_a: assert property (@(posedge core_clk) disable iff (!rst_n_r)
      rd_strobe |=> rd_data_r[0] == $past(data_settling))
      else $error("busy bit not re-evaluated");
endmodule
`default_nettype wire

// ==== hv_host_model.sv ====
// Host model that reads the status registers and reruns configuration
`timescale 1ns/1ps
`default_nettype none
module hv_host_model (
   input wire logic core_clk, // Clock
   input wire logic [7:0] rd_data_r, // Read data from the bank
   output logic rd_strobe, // Read pulse
   output logic rd_sel, // Register select
   output logic config_mode, // Configuration mode level
   output logic config_begin_command, // Begin pulse
   output logic config_end_command // End pulse
);
   // =====================================
   // Idle levels
   initial begin
      rd_strobe = 1'b0;
      rd_sel = 1'b0;
      config_mode = 1'b0;
      config_begin_command = 1'b0;
      config_end_command = 1'b0;
   end
   // =====================================
   // Transactions
   // Strobe taken at one edge, data sampled one and a half cycles later
   task automatic rd(input logic sel, output logic [7:0] d);
      @(negedge core_clk);
      rd_sel = sel;
      rd_strobe = 1'b1;
      @(negedge core_clk);
      rd_strobe = 1'b0;
      @(negedge core_clk);
      d = rd_data_r;
   endtask
   // Whole sequence again, as after a mismatch report
   task automatic open_config();
      @(negedge core_clk);
      config_mode = 1'b1;
      config_begin_command = 1'b1;
      @(negedge core_clk);
      config_begin_command = 1'b0;
   endtask
   task automatic close_config();
      @(negedge core_clk);
      config_end_command = 1'b1;
      @(negedge core_clk);
      config_end_command = 1'b0;
      config_mode = 1'b0;
   endtask
   task automatic reconfigure();
      open_config();
      close_config();
   endtask
endmodule
`default_nettype wire

// ==== hv_side_fault_status_flags_tb_top.sv ====
// Testbench for the high-side fault and state flag bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module hv_side_fault_status_flags_tb_top;
   import hv_flags_pkg::*;
   logic core_clk, resetn, fb, uvl, settle, ex, prot, short3;
   logic rd_strobe, rd_sel, cfg_mode, cfg_begin, cfg_end;
   logic [9:0] c;
   logic [2:0] ev;
   logic [7:0] rd_data_r, d;
   int errors = 0;
   int check_count = 0;
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   hv_side_fault_status_flags hv_side_fault_status_flags_i (
      .core_clk(core_clk), .resetn(resetn), .positive_gate_supply_ov(c[0]),
      .negative_gate_supply_ov(c[1]), .collector_monitor_pin(c[2]), .shunt_trip(c[3]),
      .positive_gate_supply_uv(c[4]), .negative_gate_supply_uv(c[5]),
      .thermal_shutdown_cmp(c[6]), .thermal_warning_cmp(c[7]), .config_mismatch(c[8]),
      .link_timeout(c[9]), .fallback_short_pin(fb), .undervoltage_latch_option(uvl),
      .flag_clear_command(ev[0]), .shutdown_pin_clear(ev[1]), .command_reset(ev[2]),
      .config_begin_command(cfg_begin), .config_end_command(cfg_end),
      .config_mode(cfg_mode), .data_settling(settle), .exit_protected(ex),
      .rd_strobe(rd_strobe), .rd_sel(rd_sel), .rd_data_r(rd_data_r),
      .protected_off_state_r(prot), .three_phase_short_state_r(short3));
   hv_host_model hv_host_model_i (
      .core_clk(core_clk), .rd_data_r(rd_data_r), .rd_strobe(rd_strobe), .rd_sel(rd_sel),
      .config_mode(cfg_mode), .config_begin_command(cfg_begin),
      .config_end_command(cfg_end));
   // =====================================
   // Shared steps
   task automatic conclude();
      if (errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Bit 0 clear command, bit 1 pin clear, bit 2 soft reset
   task automatic pulse(input logic [2:0] m);
      @(negedge core_clk);
      ev = m;
      @(negedge core_clk);
      ev = 3'h0;
      cyc(2);
   endtask
   task automatic blip(input int i);
      c[i] = 1'b1;
      cyc(1);
      c[i] = 1'b0;
      cyc(3);
   endtask
   task automatic rd(input logic sel, input logic [7:0] mask, input logic [7:0] e);
      hv_host_model_i.rd(sel, d);
      `CHK(d & mask, e)
   endtask
   // =====================================
   // Scenarios
   task automatic t_reset();
      `CHK(prot, 1'b1)
      rd(SEL_STATE, 8'hFF, STATE_RST);
      rd(SEL_FAULT, 8'hFF, FAULT_RST);
      settle = 1'b1;
      rd(SEL_FAULT, 8'hFF, 8'h01);
      rd(SEL_STATE, 8'h01, 8'h01);
      settle = 1'b0;
      rd(SEL_FAULT, 8'hFF, 8'h00);
   endtask
   task automatic t_clear();
      pulse(3'h1);
      rd(SEL_STATE, 8'hFF, 8'h88);
      ex = 1'b1;
      cyc(3);
      rd(SEL_STATE, 8'hFF, 8'h08);
      `CHK(prot, 1'b0)
      hv_host_model_i.reconfigure();
      cyc(2);
      rd(SEL_STATE, 8'hFF, 8'h00);
   endtask
   task automatic t_latched();
      for (int i = 0; i < 4; i++) begin
         blip(i);
         rd(SEL_FAULT, 8'hFE, 8'h80 >> i);
         `CHK(prot, 1'b1)
         pulse(i[0] ? 3'h2 : 3'h1);
         rd(SEL_FAULT, 8'hFE, 8'h00);
      end
      c[2] = 1'b1;
      pulse(3'h1);
      rd(SEL_FAULT, 8'hFE, 8'h20);
      c[2] = 1'b0;
      pulse(3'h1);
   endtask
   task automatic t_levels();
      for (int j = 0; j < 2; j++) begin
         uvl = 1'b0;
         c[4 + j] = 1'b1;
         cyc(3);
         rd(SEL_FAULT, 8'hFE, 8'h08 >> j);
         c[4 + j] = 1'b0;
         cyc(3);
         rd(SEL_FAULT, 8'hFE, 8'h00);
         uvl = 1'b1;
         blip(4 + j);
         rd(SEL_FAULT, 8'hFE, 8'h08 >> j);
         pulse(3'h1);
      end
      c[6] = 1'b1;
      cyc(3);
      rd(SEL_FAULT, 8'hFE, 8'h02);
      `CHK(prot, 1'b1)
      c[6] = 1'b0;
      c[7] = 1'b1;
      cyc(4);
      rd(SEL_STATE, 8'hFE, 8'h10);
      `CHK(prot, 1'b0)
      c[7] = 1'b0;
   endtask
   task automatic t_soft();
      blip(2);
      pulse(3'h4);
      rd(SEL_FAULT, 8'hFE, 8'h00);
      rd(SEL_STATE, 8'hFE, STATE_RST);
      pulse(3'h1);
      hv_host_model_i.reconfigure();
   endtask
   task automatic t_link();
      fb = 1'b1;
      blip(9);
      `CHK(short3, 1'b1)
      rd(SEL_STATE, 8'h02, 8'h02);
      blip(1);
      blip(5);
      `CHK(short3, 1'b1)
      blip(8);
      rd(SEL_STATE, 8'h04, 8'h04);
      hv_host_model_i.reconfigure();
      pulse(3'h1);
      rd(SEL_STATE, 8'h06, 8'h00);
      // Timeout with the fallback pin low leads to protected-off
      fb = 1'b0;
      blip(9);
      `CHK({prot, short3}, 2'h2)
      rd(SEL_STATE, 8'h82, 8'h82);
      pulse(3'h1);
   endtask
   // Power-on of the high side while configuration is open
   task automatic t_por_cfg();
      hv_host_model_i.open_config();
      resetn = 1'b0;
      cyc(2);
      `CHK({prot, short3}, 2'h2)
      resetn = 1'b1;
      cyc(3);
      rd(SEL_STATE, 8'hFE, STATE_RST);
      hv_host_model_i.close_config();
      cyc(2);
      rd(SEL_STATE, 8'h08, 8'h00);
   endtask
   // =====================================
   // Sequence and watchdog
   initial begin
      c = '0;
      ev = '0;
      {fb, uvl, settle, ex} = 4'h0;
      resetn = 1'b0;
      cyc(12);
      resetn = 1'b1;
      cyc(3);
      t_reset();
      t_clear();
      t_latched();
      t_levels();
      t_soft();
      t_link();
      t_por_cfg();
      conclude();
   end
   // Whole run is a few hundred cycles; this allows ample margin
   initial begin
      #5000000;
      errors++;
      conclude();
   end
endmodule
`default_nettype wire
